// File: hdl/cc_sbu_pkg.sv
// shared constants, register map and state types of the cc/sbu switch control
package cc_sbu_pkg;
	// clock and timing
	localparam int CLK_HZ = 40_000_000;
	localparam int CC_WAIT_MS = 120;
	localparam int SBU_GAP_US = 1000;
	localparam int DRY_STEP_MS = 100;
	localparam int MEAS_US = 400;
	localparam int CC_WAIT_CYC = CLK_HZ / 1000 * CC_WAIT_MS;
	localparam int SBU_GAP_CYC = CLK_HZ / 1_000_000 * SBU_GAP_US;
	localparam int DRY_STEP_CYC = CLK_HZ / 1000 * DRY_STEP_MS;
	localparam int MEAS_CYC = CLK_HZ / 1_000_000 * MEAS_US;
	localparam logic [4:0] SOFT_OPEN_CYC = 5'h10;
	localparam logic [1:0] STRAP_WAIT = 2'h3;
	// bus identity
	localparam logic [6:0] DEV_ADDR = 7'h28;
	localparam logic [7:0] ID_VALUE = 8'hA5; // arbitrary value
	// register offsets
	localparam logic [7:0] REG_ID = 8'h01;
	localparam logic [7:0] REG_CTRL = 8'h02;
	localparam logic [7:0] REG_INTR = 8'h03;
	localparam logic [7:0] REG_MASK = 8'h04;
	localparam logic [7:0] REG_STAT = 8'h05;
	localparam logic [7:0] REG_MOS = 8'h06;
	localparam logic [7:0] REG_SWC = 8'h07;
	localparam logic [7:0] REG_TIMER = 8'h0A;
	localparam logic [7:0] REG_RESET = 8'h0B;
	// field positions
	localparam int CTRL_MAN = 0;
	localparam int CTRL_EN_CC = 1;
	localparam int CTRL_EN_SBU = 2;
	localparam int CTRL_AUTO = 4;
	localparam int CTRL_DRY = 5;
	localparam int CTRL_DBG = 7;
	localparam int INT_W = 6;
	localparam int INT_OVP = 0;
	localparam int INT_REC = 1;
	localparam int INT_MOS = 2;
	localparam int INT_DRY = 3;
	localparam int INT_T1 = 4;
	localparam int INT_T2 = 5;
	localparam int SWC_CC = 0;
	localparam int SWC_SBU = 1;
	localparam int SWC_PROBE = 2;
	localparam int RST_DEV = 0;
	localparam int RST_MOS = 1;
	// reset values
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [5:0] MASK_RST = 6'h00;
	localparam logic [2:0] SWC_RST = 3'h3;
	localparam logic [6:0] TDRY_RST = 7'h0A;
	localparam logic [6:0] TDRY_MAX = 7'h64;
	// synchroniser lanes
	localparam int S_VDD = 0;
	localparam int S_OCC1 = 1;
	localparam int S_OCC2 = 2;
	localparam int S_OSBU1 = 3;
	localparam int S_OSBU2 = 4;
	localparam int S_R1 = 5;
	localparam int S_R2 = 6;
	localparam int S_PROBE = 7;
	localparam int S_WET = 8;
	localparam int S_SCL = 9;
	localparam int S_SDA = 10;
	localparam int SYNC_W = 11;
	typedef enum logic [2:0] {I_IDLE, I_ADDR, I_WR, I_ACK, I_RD} i2c_state_t;
	typedef enum logic [2:0] {M_IDLE, M_CC_MEAS, M_CC_WAIT, M_SBU1, M_SBU2,
		M_DRY} moist_state_t;
endpackage

// File: hdl/bit_sync.sv
// two flip-flop synchroniser for a vector of independent levels
`timescale 1ns/1ps
module bit_sync #(
	parameter int W = 1
) (
	input wire logic ref_clk, // block clock
	input wire logic rst_b, // async reset, active low
	input wire logic clk_en, // freezes state while low
	input wire logic [W-1:0] d, // asynchronous levels
	output logic [W-1:0] q // synchronised levels
);
	logic [W-1:0] meta;

	// first stage feeds only the second stage
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			meta <= '0;
			q <= '0;
		end else if (clk_en) begin
			meta <= d;
			q <= meta;
		end
	end
endmodule

// File: hdl/interval_timer.sv
// reloadable down-counter giving a one-cycle pulse when it runs out
`timescale 1ns/1ps
module interval_timer #(
	parameter int W = 32
) (
	input wire logic ref_clk, // block clock
	input wire logic rst_b, // async reset, active low
	input wire logic clk_en, // freezes state while low
	input wire logic load, // restart with load_val
	input wire logic [W-1:0] load_val, // length in cycles
	output logic done // one-cycle expiry pulse
);
	logic [W-1:0] cnt;
	logic run;

	// a zero length still counts one cycle
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt <= '0;
			run <= 1'b0;
			done <= 1'b0;
		end else if (clk_en) begin
			done <= 1'b0;
			if (load) begin
				cnt <= (load_val == '0) ? W'(1) : load_val;
				run <= 1'b1;
			end else if (run) begin
				cnt <= cnt - W'(1);
				if (cnt == W'(1)) begin
					run <= 1'b0;
					done <= 1'b1;
				end
			end
		end
	end
endmodule

// File: hdl/cc_sbu_protection_switch_ctrl.sv
// switch, alert, moisture sequencing and i2c register access of the block
`timescale 1ns/1ps
module cc_sbu_protection_switch_ctrl #(
	parameter int unsigned CC_WAIT_CYCLES = cc_sbu_pkg::CC_WAIT_CYC,
	parameter int unsigned SBU_GAP_CYCLES = cc_sbu_pkg::SBU_GAP_CYC,
	parameter int unsigned DRY_STEP_CYCLES = cc_sbu_pkg::DRY_STEP_CYC,
	parameter int unsigned MEAS_CYCLES = cc_sbu_pkg::MEAS_CYC
) (
	input wire logic ref_clk, // 40 MHz block clock
	input wire logic rst_b, // async reset, active low
	input wire logic clk_en, // freezes all state while low
	input wire logic vdd_valid, // supply above lockout level
	input wire logic conn_ovp_cc1, // connector cc1 over-voltage
	input wire logic conn_ovp_cc2, // connector cc2 over-voltage
	input wire logic conn_ovp_sbu1, // connector sbu1 over-voltage
	input wire logic conn_ovp_sbu2, // connector sbu2 over-voltage
	input wire logic host_side_cfg_line_1, // host cc1 above rise level
	input wire logic host_side_cfg_line_2, // host cc2 above rise level
	input wire logic factory_probe_pin, // probe pin level, low if grounded
	input wire logic adc_wet, // measurement below wet threshold
	input wire logic scl_in, // i2c clock pin level
	input wire logic sda_in, // i2c data pin level
	output logic sda_out, // i2c data drive value, always low
	output logic sda_oe, // i2c data pulled low while high
	output logic host_alert_n_out, // alert drive value, always low
	output logic host_alert_n_oe, // alert pulled low while high
	output logic cc_sw_close, // close both cc pass switches
	output logic sbu_sw_close, // close both sbu pass switches
	output logic rd_apply, // sink pull-downs on both cc lines
	output logic probe_to_sbu1, // probe pin joined to sbu1
	output logic probe_to_sbu2, // probe pin joined to sbu2
	output logic [1:0] cc_test_src, // test source on cc1 / cc2
	output logic [1:0] sbu_test_src // test source on sbu1 / sbu2
);
	import cc_sbu_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// input synchronisation and edges
	logic [SYNC_W-1:0] raw, syn;
	logic scl_q, sda_q, ovp_cc_q, ovp_sbu_q, both_q;
	logic vdd_ok, ovp_cc, ovp_sbu, scl, sda, both_hi, both_rise;
	logic scl_rise, scl_fall, bus_start, bus_stop;

	assign raw = {sda_in, scl_in, adc_wet, factory_probe_pin,
		host_side_cfg_line_2, host_side_cfg_line_1, conn_ovp_sbu2,
		conn_ovp_sbu1, conn_ovp_cc2, conn_ovp_cc1, vdd_valid};

	bit_sync #(.W(SYNC_W)) u_sync (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.clk_en(clk_en),
		.d(raw),
		.q(syn)
	);

	// only connector-side comparators feed protection
	assign ovp_cc = syn[S_OCC1] | syn[S_OCC2];
	assign ovp_sbu = syn[S_OSBU1] | syn[S_OSBU2];
	assign vdd_ok = syn[S_VDD];
	assign scl = syn[S_SCL];
	assign sda = syn[S_SDA];
	assign both_hi = syn[S_R1] & syn[S_R2];
	assign both_rise = both_hi & ~both_q;
	assign scl_rise = scl & ~scl_q;
	assign scl_fall = ~scl & scl_q;
	assign bus_start = scl & scl_q & sda_q & ~sda;
	assign bus_stop = scl & scl_q & ~sda_q & sda;

	// previous samples for edge detection
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			{scl_q, sda_q, ovp_cc_q, ovp_sbu_q, both_q} <= 5'h00;
		end else if (clk_en) begin
			{scl_q, sda_q, ovp_cc_q, ovp_sbu_q, both_q} <=
				{scl, sda, ovp_cc, ovp_sbu, both_hi};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// i2c slave: pointer byte, then data bytes with auto-increment
	i2c_state_t ist;
	logic [3:0] bcnt;
	logic [7:0] shreg, ptr, wr_addr, wr_data, rd_addr, rd_word;
	logic rw, ptr_phase, wr_stb, rd_stb;

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			ist <= I_IDLE;
			{bcnt, shreg, ptr, rw, ptr_phase} <= 22'h000000;
			{wr_stb, rd_stb, sda_oe, sda_out} <= 4'h0;
			{wr_addr, wr_data, rd_addr} <= 24'h000000;
		end else if (clk_en) begin
			wr_stb <= 1'b0;
			rd_stb <= 1'b0;
			if (bus_start) begin
				ist <= I_ADDR;
				bcnt <= 4'h0;
				sda_oe <= 1'b0;
				ptr_phase <= 1'b1;
			end else if (bus_stop) begin
				ist <= I_IDLE;
				sda_oe <= 1'b0;
			end else begin
				unique case (ist)
				I_IDLE: begin
				end
				I_ADDR, I_WR: begin
					if (scl_rise && bcnt != 4'h8) begin
						shreg <= {shreg[6:0], sda};
						bcnt <= bcnt + 4'h1;
					end else if (scl_fall && bcnt == 4'h8) begin
						if (ist == I_ADDR) begin
							// own address only, lsb selects direction
							if (shreg[7:1] == DEV_ADDR) begin
								sda_oe <= 1'b1;
								rw <= shreg[0];
								ist <= I_ACK;
							end else begin
								ist <= I_IDLE;
							end
						end else begin
							sda_oe <= 1'b1;
							ist <= I_ACK;
							ptr_phase <= 1'b0;
							if (ptr_phase) begin
								ptr <= shreg;
							end else begin
								wr_stb <= 1'b1;
								wr_addr <= ptr;
								wr_data <= shreg;
								ptr <= ptr + 8'h01;
							end
						end
					end
				end
				I_ACK: begin
					// a released line at an ack slot is a master nack
					if (scl_rise && sda) begin
						ist <= I_IDLE;
					end else if (scl_fall) begin
						bcnt <= 4'h0;
						if (rw) begin
							shreg <= rd_word;
							rd_stb <= 1'b1;
							rd_addr <= ptr;
							ptr <= ptr + 8'h01;
							sda_oe <= ~rd_word[7];
							ist <= I_RD;
						end else begin
							sda_oe <= 1'b0;
							ist <= I_WR;
						end
					end
				end
				I_RD: begin
					if (scl_fall) begin
						if (bcnt == 4'h7) begin
							sda_oe <= 1'b0;
							ist <= I_ACK;
						end else begin
							sda_oe <= ~shreg[6];
							shreg <= {shreg[6:0], 1'b0};
							bcnt <= bcnt + 4'h1;
						end
					end
				end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// register file
	logic [7:0] ctrl;
	logic [5:0] mask, intr, next_intr, ev, ev_set;
	logic [2:0] swc;
	logic [6:0] tdry, dsel;
	logic [3:0] wet_stat;
	logic [7:0] stat;
	logic alert, next_alert, intr_clr, dev_rst, mos_rst;
	logic look_cc, look_sbu, look_dry;

	assign dev_rst = wr_stb && wr_addr == REG_RESET && wr_data[RST_DEV];
	assign mos_rst = dev_rst ||
		(wr_stb && wr_addr == REG_RESET && wr_data[RST_MOS]);
	assign intr_clr = rd_stb && rd_addr == REG_INTR;
	assign stat = {look_cc, look_sbu, 1'b0, look_dry, 2'h0, ovp_sbu, ovp_cc};
	assign rd_word =
		(ptr == REG_ID) ? ID_VALUE :
		(ptr == REG_CTRL) ? ctrl :
		(ptr == REG_INTR) ? {2'h0, intr} :
		(ptr == REG_MASK) ? {2'h0, mask} :
		(ptr == REG_STAT) ? stat :
		(ptr == REG_MOS) ? {4'h0, wet_stat} :
		(ptr == REG_SWC) ? {5'h00, swc} :
		(ptr == REG_TIMER) ? {1'b0, tdry} : 8'h00;

	// masked events never set a bit; a new set beats a same-cycle read clear
	assign ev_set = ev & ~mask;
	assign next_intr = (intr & {INT_W{~intr_clr}}) | ev_set;
	assign next_alert = (|ev_set) | (alert & ~intr_clr);

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			{ctrl, mask, swc, tdry} <= {CTRL_RST, MASK_RST, SWC_RST, TDRY_RST};
			intr <= 6'h00;
			alert <= 1'b0;
		end else if (clk_en) begin
			if (dev_rst) begin
				{ctrl, mask, swc, tdry} <=
					{CTRL_RST, MASK_RST, SWC_RST, TDRY_RST};
				intr <= 6'h00;
				alert <= 1'b0;
			end else begin
				if (wr_stb && wr_addr == REG_CTRL) ctrl <= wr_data;
				if (wr_stb && wr_addr == REG_MASK) mask <= wr_data[5:0];
				if (wr_stb && wr_addr == REG_SWC) swc <= wr_data[2:0];
				if (wr_stb && wr_addr == REG_TIMER) tdry <= wr_data[6:0];
				intr <= next_intr;
				alert <= next_alert;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// brief switch opening after soft reset, and probe strap capture
	logic [4:0] open_cnt;
	logic [1:0] strap_cnt;
	logic probe_free;

	// strap sampled once the synchroniser holds a real pin level
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			open_cnt <= 5'h00;
			strap_cnt <= STRAP_WAIT;
			probe_free <= 1'b0;
		end else if (clk_en) begin
			if (dev_rst) begin
				open_cnt <= SOFT_OPEN_CYC;
				strap_cnt <= STRAP_WAIT;
			end else begin
				if (open_cnt != 5'h00) open_cnt <= open_cnt - 5'h01;
				if (strap_cnt != 2'h0) strap_cnt <= strap_cnt - 2'h1;
			end
			if (strap_cnt == 2'h1) probe_free <= syn[S_PROBE];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// moisture sequencing
	moist_state_t mst, next_mst;
	logic tgt, tried, alt, sbu_done, auto_pend, dry_mode, mos_lock;
	logic [1:0] cc_wet, sbu_wet;
	logic tmr_load, tmr_done, cc_go, en_cc, en_sbu;
	logic [31:0] tmr_val, dry_cyc;
	logic wet_now, sbu_any, ev_mos, ev_dry, ev_t1, ev_t2;

	assign en_cc = ctrl[CTRL_EN_CC];
	assign en_sbu = ctrl[CTRL_EN_SBU];
	assign wet_now = syn[S_WET];
	assign sbu_any = wet_now | sbu_wet[0];
	// accessory mode acts only on every other both-cc rise
	assign cc_go = both_rise & (~ctrl[CTRL_DBG] | alt);
	assign dsel = (tdry == 7'h00) ? 7'h01 :
		(tdry > TDRY_MAX) ? TDRY_MAX : tdry;
	assign dry_cyc = 32'(dsel) * 32'(DRY_STEP_CYCLES);
	assign wet_stat = {sbu_wet, cc_wet};
	assign look_cc = (mst == M_CC_MEAS) || (mst == M_CC_WAIT);
	assign look_sbu = (mst == M_SBU1) || (mst == M_SBU2);
	assign look_dry = (mst == M_DRY);

	interval_timer #(.W(32)) u_tmr (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.clk_en(clk_en),
		.load(tmr_load),
		.load_val(tmr_val),
		.done(tmr_done)
	);

	// next state, timer reloads and moisture events
	always_comb begin
		next_mst = mst;
		tmr_load = 1'b0;
		tmr_val = 32'(MEAS_CYCLES);
		ev_mos = 1'b0;
		ev_dry = 1'b0;
		ev_t1 = 1'b0;
		ev_t2 = 1'b0;
		unique case (mst)
		M_IDLE: begin
			if (en_cc && cc_go) begin
				next_mst = M_CC_MEAS;
				tmr_load = 1'b1;
			end else if ((en_sbu || auto_pend) && !sbu_done) begin
				next_mst = M_SBU1;
				tmr_load = 1'b1;
				tmr_val = 32'(SBU_GAP_CYCLES);
			end
		end
		M_CC_MEAS: begin
			if (tmr_done && tried) begin
				next_mst = M_IDLE;
				ev_mos = wet_now | (|cc_wet);
			end else if (tmr_done) begin
				next_mst = M_CC_WAIT;
				tmr_load = 1'b1;
				tmr_val = 32'(CC_WAIT_CYCLES);
			end
		end
		M_CC_WAIT: begin
			if (cc_go) begin
				next_mst = M_CC_MEAS;
				tmr_load = 1'b1;
			end else if (tmr_done) begin
				next_mst = M_IDLE;
				ev_t1 = ~tgt;
				ev_t2 = tgt;
			end
		end
		M_SBU1: begin
			if (tmr_done) begin
				next_mst = M_SBU2;
				tmr_load = 1'b1;
				tmr_val = 32'(SBU_GAP_CYCLES);
			end
		end
		M_SBU2: begin
			if (tmr_done) begin
				ev_mos = sbu_any & ~dry_mode;
				ev_dry = ~sbu_any & dry_mode;
				if (sbu_any && ctrl[CTRL_DRY]) begin
					next_mst = M_DRY;
					tmr_load = 1'b1;
					tmr_val = dry_cyc;
				end else begin
					next_mst = M_IDLE;
				end
			end
		end
		M_DRY: begin
			if (tmr_done) begin
				next_mst = M_SBU1;
				tmr_load = 1'b1;
				tmr_val = 32'(SBU_GAP_CYCLES);
			end
		end
		endcase
		if (mos_rst || (!en_cc && look_cc)) begin
			next_mst = M_IDLE;
		end
	end

	// sequencing state and stored results
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			mst <= M_IDLE;
			{tgt, tried, alt, sbu_done, auto_pend, dry_mode} <= 6'h00;
			{mos_lock, cc_wet, sbu_wet} <= 5'h00;
		end else if (clk_en) begin
			mst <= next_mst;
			if (both_rise) alt <= ~alt;
			if (mos_rst) begin
				{tgt, tried, sbu_done, auto_pend, dry_mode} <= 5'h00;
				{mos_lock, cc_wet, sbu_wet} <= 5'h00;
			end else begin
				if (mst == M_CC_MEAS && tmr_done) begin
					cc_wet[tgt] <= wet_now;
					tgt <= ~tgt;
					tried <= ~tried;
					if (tried && ctrl[CTRL_AUTO] && (wet_now || |cc_wet))
						auto_pend <= 1'b1;
				end
				if (mst == M_CC_WAIT && tmr_done) tried <= 1'b0;
				if (mst == M_SBU1 && tmr_done) sbu_wet[0] <= wet_now;
				if (mst == M_SBU2 && tmr_done) begin
					sbu_wet[1] <= wet_now;
					mos_lock <= sbu_any;
					dry_mode <= sbu_any & ctrl[CTRL_DRY];
					sbu_done <= 1'b1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// switch control: protection and moisture first, then manual, then auto
	logic man, cc_base, sbu_base, mos_cc_open, mos_sbu_open, hold_open;
	logic next_cc, next_sbu, next_p1, next_p2;
	logic [1:0] next_cc_src, next_sbu_src;

	assign man = ctrl[CTRL_MAN];
	assign hold_open = !vdd_ok || open_cnt != 5'h00;
	assign mos_cc_open = (mst == M_CC_MEAS) || look_sbu || look_dry ||
		mos_lock;
	assign mos_sbu_open = look_sbu || look_dry || mos_lock;
	assign cc_base = man ? swc[SWC_CC] : 1'b1;
	assign sbu_base = man ? swc[SWC_SBU] : ~probe_free;
	assign next_cc = !hold_open && !ovp_cc && !mos_cc_open && cc_base;
	assign next_sbu = !hold_open && !ovp_sbu && !mos_sbu_open &&
		sbu_base;
	assign next_p1 = probe_free && vdd_ok && !swc[SWC_PROBE];
	assign next_p2 = probe_free && vdd_ok && swc[SWC_PROBE];
	assign next_cc_src = (mst == M_CC_MEAS) ? {tgt, ~tgt} : 2'h0;
	assign next_sbu_src = {mst == M_SBU2, mst == M_SBU1};

	// over-voltage trip and recovery events
	assign ev[INT_OVP] = (ovp_cc & ~ovp_cc_q) | (ovp_sbu & ~ovp_sbu_q);
	assign ev[INT_REC] = (~ovp_cc & ovp_cc_q) | (~ovp_sbu & ovp_sbu_q);
	// moisture events land on their own bits; one driver per bit
	assign ev[INT_MOS] = ev_mos;
	assign ev[INT_DRY] = ev_dry;
	assign ev[INT_T1] = ev_t1;
	assign ev[INT_T2] = ev_t2;

	// registered pin outputs; switches open during reset and lockout
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			{cc_sw_close, sbu_sw_close, probe_to_sbu1, probe_to_sbu2} <= 4'h0;
			rd_apply <= 1'b1;
			{cc_test_src, sbu_test_src} <= 4'h0;
			{host_alert_n_out, host_alert_n_oe} <= 2'h0;
		end else if (clk_en) begin
			cc_sw_close <= next_cc;
			sbu_sw_close <= next_sbu;
			probe_to_sbu1 <= next_p1;
			probe_to_sbu2 <= next_p2;
			rd_apply <= !vdd_ok;
			cc_test_src <= next_cc_src;
			sbu_test_src <= next_sbu_src;
			host_alert_n_oe <= next_alert;
		end
	end
endmodule

// File: testbench/cc_sbu_ctrl_props.sv
// concurrent checks on the switch control ports
`timescale 1ns/1ps
module cc_sbu_ctrl_props (
	input wire logic ref_clk, // block clock
	input wire logic rst_b, // async reset, active low
	input wire logic vdd_valid, // supply good
	input wire logic conn_ovp_cc1, // cc1 over-voltage
	input wire logic conn_ovp_cc2, // cc2 over-voltage
	input wire logic conn_ovp_sbu1, // sbu1 over-voltage
	input wire logic conn_ovp_sbu2, // sbu2 over-voltage
	input wire logic factory_probe_pin, // strap level
	input wire logic scl_in, // i2c clock pin
	input wire logic cc_sw_close, // cc pair closed
	input wire logic sbu_sw_close, // sbu pair closed
	input wire logic rd_apply, // sink pull-downs on
	input wire logic host_alert_n_oe // alert pulled low
);
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (!rst_b);
	////////////////////////////////////////////////////////////////////////
	// four samples cover two sync stages plus the output register
	property p_por;
		$rose(rst_b) && vdd_valid |-> ##[2:4] cc_sw_close;
	endproperty
	a_por: assert property (p_por)
		else $error("cc pair not closed after reset");
	property p_rd;
		!vdd_valid [*4] |-> rd_apply;
	endproperty
	a_rd: assert property (p_rd)
		else $error("pull-downs missing without supply");
	property p_uvlo;
		!vdd_valid [*4] |-> !cc_sw_close && !sbu_sw_close;
	endproperty
	a_uvlo: assert property (p_uvlo)
		else $error("switch closed in lockout");
	property p_cc_ovp;
		(conn_ovp_cc1 || conn_ovp_cc2) [*4] |-> !cc_sw_close;
	endproperty
	a_cc_ovp: assert property (p_cc_ovp)
		else $error("cc pair closed under over-voltage");
	property p_sbu_ovp;
		(conn_ovp_sbu1 || conn_ovp_sbu2) [*4] |-> !sbu_sw_close;
	endproperty
	a_sbu_ovp: assert property (p_sbu_ovp)
		else $error("sbu pair closed under over-voltage");
	property p_alert;
		$rose(conn_ovp_cc1 || conn_ovp_cc2) |-> ##[1:6] host_alert_n_oe;
	endproperty
	a_alert: assert property (p_alert)
		else $error("no alert after over-voltage");
	// release only comes from a bus access, which ends in the scl low phase
	property p_alert_rel;
		$fell(host_alert_n_oe) |-> !scl_in;
	endproperty
	a_alert_rel: assert property (p_alert_rel)
		else $error("alert released outside a bus access");
	property p_strap;
		$rose(rst_b) && vdd_valid && !factory_probe_pin
			|-> ##[2:5] sbu_sw_close;
	endproperty
	a_strap: assert property (p_strap)
		else $error("grounded strap left sbu pair open");
endmodule
bind cc_sbu_protection_switch_ctrl cc_sbu_ctrl_props u_props (.ref_clk,
	.rst_b, .vdd_valid, .conn_ovp_cc1, .conn_ovp_cc2, .conn_ovp_sbu1,
	.conn_ovp_sbu2, .factory_probe_pin, .scl_in, .cc_sw_close,
	.sbu_sw_close, .rd_apply, .host_alert_n_oe);

// File: testbench/i2c_host_model.sv
// i2c master standing in for the host processor
`timescale 1ns/1ps
module i2c_host_model (
	output logic scl, // clock pin, stands high between frames
	output logic sda_low, // high while the model pulls data low
	input wire logic sda // wired data line level
);
	localparam int Q = 25; // eighth of the 200 ns bit time
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	// long low phase lets the slave release ack before the next rise
	task automatic bit_io(input logic b, output logic r);
		#Q sda_low = !b;
		#(4*Q) scl = 1'b1;
		#(2*Q) r = sda;
		scl = 1'b0;
		#Q;
	endtask
	task automatic start_cond();
		#(2*Q) sda_low = 1'b0;
		#(4*Q) scl = 1'b1;
		#(4*Q) sda_low = 1'b1;
		#(4*Q) scl = 1'b0;
	endtask
	task automatic stop_cond();
		#Q sda_low = 1'b1;
		#(4*Q) scl = 1'b1;
		#(4*Q) sda_low = 1'b0;
		#(8*Q);
	endtask
	// msb first, ninth bit is sent by mack or sampled as ack
	task automatic byte_io(input logic [7:0] d, input logic mack,
		output logic [7:0] r, output logic ack);
		logic b;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], b);
			r[i] = b;
		end
		bit_io(mack, b);
		ack = !b;
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] p, d,
		output logic ok);
		logic [7:0] r;
		logic k1, k2, k3;
		start_cond();
		byte_io({a, 1'b0}, 1'b1, r, k1);
		byte_io(p, 1'b1, r, k2);
		byte_io(d, 1'b1, r, k3);
		stop_cond();
		ok = k1 & k2 & k3;
	endtask
	// pointer write, repeated start, one byte read with nack
	task automatic rd(input logic [7:0] p, output logic [7:0] d,
		output logic ok);
		logic [7:0] r;
		logic k1, k2, k3, k4;
		start_cond();
		byte_io({cc_sbu_pkg::DEV_ADDR, 1'b0}, 1'b1, r, k1);
		byte_io(p, 1'b1, r, k2);
		start_cond();
		byte_io({cc_sbu_pkg::DEV_ADDR, 1'b1}, 1'b1, r, k3);
		byte_io(8'hFF, 1'b1, d, k4);
		stop_cond();
		ok = k1 & k2 & k3;
	endtask
endmodule

// File: testbench/cc_sbu_protection_switch_ctrl_tb.sv
// self-checking bench of the cc/sbu switch control
`timescale 1ns/1ps
module cc_sbu_protection_switch_ctrl_tb;
	import cc_sbu_pkg::*;
	logic ref_clk, rst_b, vdd_valid, factory_probe_pin, ok;
	logic [3:0] ovp; // cc1, cc2, sbu1, sbu2
	logic scl, m_low, sda_oe, host_alert_n_oe, cc_sw_close, sbu_sw_close;
	logic rd_apply, probe_to_sbu1, probe_to_sbu2;
	logic [1:0] cfg, cc_test_src; // host cc rise levels, cc test source
	logic wet, sda_out, host_alert_n_out;
	logic [7:0] rdat;
	int err_count, compares, low_cnt;
	wire sda = !(sda_oe || m_low); // open drain with pull-up
	cc_sbu_protection_switch_ctrl #(.CC_WAIT_CYCLES(200),
		.SBU_GAP_CYCLES(20), .DRY_STEP_CYCLES(50), .MEAS_CYCLES(10)) dut (
		.ref_clk, .rst_b, .clk_en(1'b1), .vdd_valid,
		.conn_ovp_cc1(ovp[0]), .conn_ovp_cc2(ovp[1]),
		.conn_ovp_sbu1(ovp[2]), .conn_ovp_sbu2(ovp[3]),
		.host_side_cfg_line_1(cfg[0]), .host_side_cfg_line_2(cfg[1]),
		.factory_probe_pin, .adc_wet(wet), .scl_in(scl), .sda_in(sda),
		.sda_out, .sda_oe, .host_alert_n_out, .host_alert_n_oe,
		.cc_sw_close, .sbu_sw_close, .rd_apply, .probe_to_sbu1,
		.probe_to_sbu2, .cc_test_src, .sbu_test_src());
	i2c_host_model host (.scl, .sda_low(m_low), .sda);
	////////////////////////////////////////////////////////////////////////
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	// cycles with the cc pair open, so a brief opening is not missed
	always @(posedge ref_clk) if (!cc_sw_close) low_cnt++;
	// hang guard: the whole run needs well under 400 us
	initial begin
		#400us;
		err_count++;
		end_of_test();
	end
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time,
				seen, exp);
		end
	endtask
	task automatic end_of_test();
		if (err_count == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	// bus pins move on the falling edge, away from the sampling edge
	task automatic wr(input logic [7:0] p, d);
		@(negedge ref_clk);
		host.wr(DEV_ADDR, p, d, ok);
		chk(ok, 1'b1);
	endtask
	task automatic rdc(input logic [7:0] p, exp);
		@(negedge ref_clk);
		host.rd(p, rdat, ok);
		chk(ok, 1'b1);
		chk(rdat, exp);
	endtask
	task automatic set_ovp(input logic [3:0] v);
		@(posedge ref_clk) ovp <= v;
		cyc(8);
	endtask
	task automatic do_reset(input logic probe);
		@(posedge ref_clk) rst_b <= 1'b0;
		factory_probe_pin <= probe;
		cyc(5);
		rst_b <= 1'b1;
		cyc(8);
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic t_power_up();
		chk({cc_sw_close, sbu_sw_close}, 2'h3);
		chk({rd_apply, host_alert_n_oe}, 2'h0);
		chk({sda_out, host_alert_n_out}, 2'h0);
		@(negedge ref_clk);
		host.wr(7'h29, REG_CTRL, 8'h01, ok);
		chk(ok, 1'b0);
		rdc(REG_ID, ID_VALUE);
		rdc(REG_CTRL, 8'h00);
		rdc(REG_MASK, 8'h00);
	endtask
	// each connector line in turn: only its own pair opens, then recloses
	task automatic t_ovp();
		for (int i = 0; i < 4; i++) begin
			set_ovp(4'h1 << i);
			chk(cc_sw_close, i > 1);
			chk(sbu_sw_close, i < 2);
			chk(host_alert_n_oe, 1'b1);
			set_ovp(4'h0);
			chk({cc_sw_close, sbu_sw_close}, 2'h3);
		end
		cyc(40);
		chk(host_alert_n_oe, 1'b1);
		rdc(REG_INTR, 8'h03);
		chk(host_alert_n_oe, 1'b0);
	endtask
	task automatic t_mask();
		wr(REG_MASK, 8'h02);
		set_ovp(4'h1);
		rdc(REG_INTR, 8'h01);
		set_ovp(4'h0);
		chk(host_alert_n_oe, 1'b0);
		rdc(REG_INTR, 8'h00);
	endtask
	task automatic t_soft_reset();
		low_cnt = 0;
		wr(REG_RESET, 8'h01);
		cyc(40);
		chk({low_cnt != 0, cc_sw_close}, 2'h3);
		rdc(REG_MASK, 8'h00);
		rdc(REG_SWC, 8'h03);
	endtask
	// setting first, enable second; over-voltage still forces open
	task automatic t_manual();
		wr(REG_SWC, 8'h02);
		wr(REG_CTRL, 8'h01);
		cyc(4);
		chk({cc_sw_close, sbu_sw_close}, 2'h1);
		set_ovp(4'h4);
		chk(sbu_sw_close, 1'b0);
		set_ovp(4'h0);
		wr(REG_CTRL, 8'h00);
		cyc(4);
		chk(cc_sw_close, 1'b1);
	endtask
	task automatic t_vdd();
		@(posedge ref_clk) vdd_valid <= 1'b0;
		cyc(6);
		chk({cc_sw_close, sbu_sw_close, rd_apply}, 3'h1);
		@(posedge ref_clk) vdd_valid <= 1'b1;
		cyc(6);
		chk({cc_sw_close, rd_apply}, 2'h2);
	endtask
	task automatic t_probe();
		do_reset(1'b1);
		chk({probe_to_sbu1, probe_to_sbu2, sbu_sw_close}, 3'h4);
		wr(REG_SWC, 8'h07);
		cyc(4);
		chk({probe_to_sbu1, probe_to_sbu2}, 2'h1);
	endtask
	// one-line rise ignored; cc1 test then timeout, then cc2 and cc1 wet
	task automatic t_moist();
		wr(REG_CTRL, 8'h02);
		@(posedge ref_clk) cfg <= 2'h1;
		cyc(8);
		chk(cc_test_src, 2'h0);
		@(posedge ref_clk) cfg <= 2'h3;
		cyc(6);
		chk({cc_test_src, cc_sw_close}, 3'h2);
		@(posedge ref_clk) cfg <= 2'h0;
		cyc(230);
		rdc(REG_INTR, 8'h20);
		@(posedge ref_clk) cfg <= 2'h3;
		wet <= 1'b1;
		cyc(6);
		chk(cc_test_src, 2'h2);
		@(posedge ref_clk) cfg <= 2'h0;
		cyc(20);
		@(posedge ref_clk) cfg <= 2'h3;
		cyc(20);
		rdc(REG_INTR, 8'h04);
		wr(REG_CTRL, 8'h00);
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		rst_b = 1'b0;
		vdd_valid = 1'b1;
		factory_probe_pin = 1'b0;
		ovp = 4'h0;
		cfg = 2'h0;
		wet = 1'b0;
		do_reset(1'b0);
		t_power_up();
		t_ovp();
		t_mask();
		t_soft_reset();
		t_manual();
		t_vdd();
		t_probe();
		t_moist();
		end_of_test();
	end
endmodule
